// ===== irq_agg_pkg.sv
`default_nettype none
package irq_agg_pkg;

  localparam int unsigned NUM_PORTS = 7;

  // byte addresses in the global page
  localparam logic [15:0] ADDR_PIN_CTRL = 16'h0006;
  localparam logic [15:0] ADDR_GLOBAL_STATUS = 16'h0010;
  localparam logic [15:0] ADDR_GLOBAL_MASK = 16'h0014;
  localparam logic [15:0] ADDR_PORT_STATUS = 16'h0018;
  localparam logic [15:0] ADDR_PORT_MASK = 16'h001c;

  // field positions
  localparam int unsigned PIN_OE_BIT = 1;
  localparam int unsigned PIN_POL_BIT = 0;
  localparam int unsigned LOOKUP_BIT = 31;
  localparam int unsigned TRIGGER_BIT = 30;
  localparam int unsigned PORT_LSB = 0;

  // values after reset
  localparam logic PIN_OE_RST = 1'h0;
  localparam logic PIN_POL_RST = 1'h0;
  localparam logic [1:0] GLOBAL_MASK_RST = 2'h0;
  localparam logic [6:0] PORT_MASK_RST = 7'h00;
  localparam logic [1:0] GLOBAL_STATUS_RST = 2'h0;
  localparam logic [6:0] PORT_STATUS_RST = 7'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // byte-wide management access
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } mgmt_req_t;

  // event sources from the switch core
  typedef struct packed {
    logic lookup_engine;
    logic trigger_unit;
    logic timestamp_unit;
    logic [6:0] port;
    logic [6:0] port_egress_ts;
  } irq_sources_t;

  // register state of the aggregator; the pin driver and reset sync keep their own flops
  typedef struct packed {
    logic pin_oe;
    logic pin_pol;
    logic [1:0] global_mask;
    logic [6:0] port_mask;
    logic [1:0] global_status;
    logic [6:0] port_status;
    logic irq;
    logic [7:0] rdata;
    logic rvalid;
  } agg_state_t;

endpackage
`default_nettype wire

// ===== irq_reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module irq_reset_sync (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  output logic o_nrst_sync
);

  logic [1:0] stage;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      stage <= 2'h0;
    end else begin
      stage <= {stage[0], 1'b1};
    end
  end

  assign o_nrst_sync = stage[1];

endmodule
`default_nettype wire

// ===== power_event_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
module power_event_pin_drv (
  input wire logic i_clk_sys,
  input wire logic i_nrst_sync,
  input wire logic i_irq,
  input wire logic i_oe,
  input wire logic i_pol,
  output logic o_pin,
  output logic o_pin_oe
);

  typedef struct packed {
    logic pin;
    logic oe;
  } pin_state_t;

  pin_state_t state;
  pin_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.oe = i_oe;
    // polarity 0 pulls low on request, 1 drives high
    next_state.pin = i_pol ? i_irq : ~i_irq;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst_sync) begin
    if (!i_nrst_sync) begin
      state <= '{pin: 1'b1, oe: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign o_pin = state.pin;
  assign o_pin_oe = state.oe;

endmodule
`default_nettype wire

// ===== global_interrupt_aggregator.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - power event pin driven only when enabled
// - polarity bit 0 active low, 1 high
// - status bit 31 mirrors lookup engine request
// - status bit 30 trigger or timestamp request
// - egress timestamp events only via port path
// - mask bit 31 zero enables lookup engine
// - mask bit 30 zero enables trigger unit
// - port status bit n-1 for port n
// - port mask bits zero enable each port
// - multi-byte registers big-endian, MSB lowest address
// - any register byte accessible in any order
module global_interrupt_aggregator (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_lookup_engine_irq,
  input wire logic i_trigger_unit_irq,
  input wire logic i_timestamp_unit_irq,
  input wire logic [6:0] i_port_irq,
  input wire logic [6:0] i_port_egress_ts_irq,
  output logic o_irq,
  output logic o_power_event_pin,
  output logic o_power_event_pin_oe
);

  logic nrst_sync;
  irq_agg_pkg::mgmt_req_t req;
  irq_agg_pkg::irq_sources_t src;
  irq_agg_pkg::agg_state_t state;
  irq_agg_pkg::agg_state_t next_state;

  assign req = '{addr: i_reg_addr, wr: i_reg_wr, rd: i_reg_rd, wdata: i_reg_wdata};
  assign src = '{lookup_engine: i_lookup_engine_irq,
                 trigger_unit: i_trigger_unit_irq,
                 timestamp_unit: i_timestamp_unit_irq,
                 port: i_port_irq,
                 port_egress_ts: i_port_egress_ts_irq};

  irq_reset_sync u_reset_sync (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .o_nrst_sync(nrst_sync)
  );

  // big-endian lane: lane 0 is the most significant byte
  function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] lane);
    logic [7:0] b;
    b = 8'h00;
    case (lane)
      2'h0: b = word[31:24];
      2'h1: b = word[23:16];
      2'h2: b = word[15:8];
      default: b = word[7:0];
    endcase
    return b;
  endfunction

  function automatic logic [31:0] put_byte(input logic [31:0] word, input logic [1:0] lane,
                                           input logic [7:0] data);
    logic [31:0] w;
    w = word;
    case (lane)
      2'h0: w[31:24] = data;
      2'h1: w[23:16] = data;
      2'h2: w[15:8] = data;
      default: w[7:0] = data;
    endcase
    return w;
  endfunction

  function automatic logic hits(input logic [15:0] addr, input logic [15:0] base);
    return addr[15:2] == base[15:2];
  endfunction

  // full 32-bit images, reserved bits zero
  logic [31:0] global_status_word;
  logic [31:0] global_mask_word;
  logic [31:0] port_status_word;
  logic [31:0] port_mask_word;
  logic [7:0] pin_ctrl_byte;
  logic [31:0] mask_written;
  logic [1:0] lane;

  always_comb begin
    global_status_word = 32'h0000_0000;
    global_status_word[irq_agg_pkg::LOOKUP_BIT] = state.global_status[1];
    global_status_word[irq_agg_pkg::TRIGGER_BIT] = state.global_status[0];
    global_mask_word = 32'h0000_0000;
    global_mask_word[irq_agg_pkg::LOOKUP_BIT] = state.global_mask[1];
    global_mask_word[irq_agg_pkg::TRIGGER_BIT] = state.global_mask[0];
    port_status_word = 32'h0000_0000;
    port_status_word[irq_agg_pkg::PORT_LSB +: irq_agg_pkg::NUM_PORTS] = state.port_status;
    port_mask_word = 32'h0000_0000;
    port_mask_word[irq_agg_pkg::PORT_LSB +: irq_agg_pkg::NUM_PORTS] = state.port_mask;
    pin_ctrl_byte = 8'h00;
    pin_ctrl_byte[irq_agg_pkg::PIN_OE_BIT] = state.pin_oe;
    pin_ctrl_byte[irq_agg_pkg::PIN_POL_BIT] = state.pin_pol;
  end

  assign lane = req.addr[1:0];

  always_comb begin
    next_state = state;
    mask_written = 32'h0000_0000;

    // summary status follows the detailed sources every cycle
    next_state.global_status[1] = src.lookup_engine;
    // egress timestamp requests deliberately left out here
    next_state.global_status[0] = src.trigger_unit | src.timestamp_unit;
    next_state.port_status = src.port | src.port_egress_ts;

    // byte writes, any lane, any order; status and reserved bits ignore writes
    if (req.wr) begin
      if (req.addr == irq_agg_pkg::ADDR_PIN_CTRL) begin
        next_state.pin_oe = req.wdata[irq_agg_pkg::PIN_OE_BIT];
        next_state.pin_pol = req.wdata[irq_agg_pkg::PIN_POL_BIT];
      end else if (hits(req.addr, irq_agg_pkg::ADDR_GLOBAL_MASK)) begin
        mask_written = put_byte(global_mask_word, lane, req.wdata);
        next_state.global_mask[1] = mask_written[irq_agg_pkg::LOOKUP_BIT];
        next_state.global_mask[0] = mask_written[irq_agg_pkg::TRIGGER_BIT];
      end else if (hits(req.addr, irq_agg_pkg::ADDR_PORT_MASK)) begin
        mask_written = put_byte(port_mask_word, lane, req.wdata);
        next_state.port_mask =
          mask_written[irq_agg_pkg::PORT_LSB +: irq_agg_pkg::NUM_PORTS];
      end
    end

    // byte reads; unmapped addresses read zero
    next_state.rvalid = req.rd;
    next_state.rdata = irq_agg_pkg::RDATA_RST;
    if (req.rd) begin
      if (req.addr == irq_agg_pkg::ADDR_PIN_CTRL) begin
        next_state.rdata = pin_ctrl_byte;
      end else if (hits(req.addr, irq_agg_pkg::ADDR_GLOBAL_STATUS)) begin
        next_state.rdata = byte_of(global_status_word, lane);
      end else if (hits(req.addr, irq_agg_pkg::ADDR_GLOBAL_MASK)) begin
        next_state.rdata = byte_of(global_mask_word, lane);
      end else if (hits(req.addr, irq_agg_pkg::ADDR_PORT_STATUS)) begin
        next_state.rdata = byte_of(port_status_word, lane);
      end else if (hits(req.addr, irq_agg_pkg::ADDR_PORT_MASK)) begin
        next_state.rdata = byte_of(port_mask_word, lane);
      end
    end

    // mask bit 0 enables; one request line for everything
    next_state.irq = |(state.global_status & ~state.global_mask)
                   | |(state.port_status & ~state.port_mask);
  end

  always_ff @(posedge i_clk_sys or negedge nrst_sync) begin
    if (!nrst_sync) begin
      state.pin_oe <= irq_agg_pkg::PIN_OE_RST;
      state.pin_pol <= irq_agg_pkg::PIN_POL_RST;
      state.global_mask <= irq_agg_pkg::GLOBAL_MASK_RST;
      state.port_mask <= irq_agg_pkg::PORT_MASK_RST;
      state.global_status <= irq_agg_pkg::GLOBAL_STATUS_RST;
      state.port_status <= irq_agg_pkg::PORT_STATUS_RST;
      state.irq <= 1'b0;
      state.rdata <= irq_agg_pkg::RDATA_RST;
      state.rvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  power_event_pin_drv u_pin_drv (
    .i_clk_sys(i_clk_sys),
    .i_nrst_sync(nrst_sync),
    .i_irq(state.irq),
    .i_oe(state.pin_oe),
    .i_pol(state.pin_pol),
    .o_pin(o_power_event_pin),
    .o_pin_oe(o_power_event_pin_oe)
  );

  assign o_irq = state.irq;
  assign o_reg_rdata = state.rdata;
  assign o_reg_rvalid = state.rvalid;

endmodule
`default_nettype wire

// ===== global_interrupt_aggregator_checker.sv
`timescale 1ns/1ps
`default_nettype none
module global_interrupt_aggregator_checker (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_lookup_engine_irq,
  input wire logic i_trigger_unit_irq,
  input wire logic i_timestamp_unit_irq,
  input wire logic [6:0] i_port_irq,
  input wire logic [6:0] i_port_egress_ts_irq,
  input wire logic o_irq,
  input wire logic o_power_event_pin,
  input wire logic o_power_event_pin_oe
);
  logic [2:0] up;
  logic src;
  assign src = i_lookup_engine_irq | i_trigger_unit_irq | i_timestamp_unit_irq
    | (|i_port_irq) | (|i_port_egress_ts_irq);
  // cycles since release, covers the internal two-flop reset copy
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      up <= 3'h0;
    end else if (up != 3'h7) begin
      up <= up + 3'h1;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence quiet_s; up == 3'h7 && !src; endsequence
  sequence no_wr3_s; (up == 3'h7 && !i_reg_wr) [*3]; endsequence
  rd_answer_a: assert property (up == 3'h7 && i_reg_rd |=> o_reg_rvalid)
    else $error("read got no answer");
  rvalid_idle_a: assert property (up == 3'h7 && !i_reg_rd |=> !o_reg_rvalid)
    else $error("answer without read");
  rdata_idle_a: assert property (up == 3'h7 && !i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  quiet_irq_a: assert property (quiet_s ##1 quiet_s |=> !o_irq)
    else $error("request with no source");
  irq_cause_a: assert property (up == 3'h7 && $rose(o_irq) |-> $past(src, 2))
    else $error("request rose without source");
  pin_steady_a: assert property (no_wr3_s ##0 $stable(o_irq)
    |=> $stable(o_power_event_pin))
    else $error("pin moved without cause");
  oe_steady_a: assert property (no_wr3_s |=> $stable(o_power_event_pin_oe))
    else $error("pin enable moved without write");
  oe_reset_a: assert property (up == 3'h3 |-> !o_power_event_pin_oe && !o_irq)
    else $error("pin enabled after reset");
endmodule
`default_nettype wire

// ===== tb_global_interrupt_aggregator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_global_interrupt_aggregator;
  typedef struct packed {
    irq_agg_pkg::irq_sources_t src;
    logic [15:0] addr;
    logic [7:0] data;
    logic irq;
  } row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  irq_agg_pkg::irq_sources_t src = '0;
  logic [7:0] rdata;
  logic rvalid, irq, pin, pin_oe;
  logic [7:0] got;
  int fail_count = 0;
  int total_checks = 0;
  logic [15:0] rst_addr [7] = '{16'h0006, 16'h0010, 16'h0014, 16'h0017, 16'h0018,
    16'h001c, 16'h001f};
  // status rows: sources, read address, byte, request
  row_t srows [9] = '{{17'h10000, 16'h0010, 8'h80, 1'b1}, {17'h08000, 16'h0010, 8'h40, 1'b1},
    {17'h04000, 16'h0010, 8'h40, 1'b1}, {17'h02080, 16'h001b, 8'h41, 1'b1},
    {17'h00002, 16'h0010, 8'h00, 1'b1}, {17'h00002, 16'h001b, 8'h02, 1'b1},
    {17'h10000, 16'h0011, 8'h00, 1'b1}, {17'h03f80, 16'h0018, 8'h00, 1'b1},
    {17'h00000, 16'h0013, 8'h00, 1'b0}};
  // mask rows: sources, write address, byte, request
  row_t mrows [9] = '{{17'h10000, 16'h0014, 8'h80, 1'b0}, {17'h10000, 16'h0014, 8'h40, 1'b1},
    {17'h08000, 16'h0014, 8'h40, 1'b0}, {17'h04000, 16'h0015, 8'hff, 1'b0},
    {17'h04000, 16'h0014, 8'h00, 1'b1}, {17'h02200, 16'h001f, 8'h44, 1'b0},
    {17'h02200, 16'h001f, 8'h04, 1'b1}, {17'h00040, 16'h001f, 8'h40, 1'b0},
    {17'h00040, 16'h001c, 8'hff, 1'b0}};
  // write then read back: address, written, expected
  row_t wrows [7] = '{{17'h0, 16'h0014, 8'hff, 1'b0}, {17'h0, 16'h0017, 8'hff, 1'b0},
    {17'h0, 16'h001f, 8'hff, 1'b0}, {17'h0, 16'h001c, 8'hff, 1'b0},
    {17'h0, 16'h0020, 8'hff, 1'b0}, {17'h0, 16'h0006, 8'hff, 1'b0},
    {17'h0, 16'h0010, 8'hff, 1'b0}};
  logic [7:0] wexp [7] = '{8'hc0, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h03, 8'h00};
  // pin rows: sources, expected {oe, pin} in addr, control byte
  row_t prows [6] = '{{17'h00000, 16'h0001, 8'h00, 1'b0}, {17'h10000, 16'h0000, 8'h00, 1'b0},
    {17'h10000, 16'h0002, 8'h02, 1'b0}, {17'h10000, 16'h0003, 8'h03, 1'b0},
    {17'h00000, 16'h0002, 8'h03, 1'b0}, {17'h00000, 16'h0003, 8'h02, 1'b0}};
  global_interrupt_aggregator uut (.i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_lookup_engine_irq(src.lookup_engine),
    .i_trigger_unit_irq(src.trigger_unit), .i_timestamp_unit_irq(src.timestamp_unit),
    .i_port_irq(src.port), .i_port_egress_ts_irq(src.port_egress_ts), .o_irq(irq),
    .o_power_event_pin(pin), .o_power_event_pin_oe(pin_oe));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_byte(input logic [15:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check(8'(rvalid), 8'h01);
    got = rdata;
  endtask
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #50000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(negedge clk);
    check({6'h00, pin_oe, pin}, 8'h01);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rst_addr[i]) begin
      rd_byte(rst_addr[i]);
      check(got, 8'h00);
    end
    foreach (srows[i]) begin
      src = srows[i].src;
      settle();
      check(8'(irq), 8'(srows[i].irq));
      rd_byte(srows[i].addr);
      check(got, srows[i].data);
    end
    foreach (mrows[i]) begin
      src = mrows[i].src;
      wr_byte(mrows[i].addr, mrows[i].data);
      settle();
      check(8'(irq), 8'(mrows[i].irq));
    end
    src = '0;
    foreach (wrows[i]) begin
      wr_byte(wrows[i].addr, wrows[i].data);
      rd_byte(wrows[i].addr);
      check(got, wexp[i]);
    end
    wr_byte(16'h0014, 8'h00);
    wr_byte(16'h001f, 8'h00);
    foreach (prows[i]) begin
      src = prows[i].src;
      wr_byte(16'h0006, prows[i].data);
      settle();
      check({6'h00, pin_oe, pin}, prows[i].addr[7:0]);
    end
    nrst = 1'b0;
    @(negedge clk);
    check({6'h00, pin_oe, irq}, 8'h00);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    rd_byte(16'h0006);
    check(got, 8'h00);
    tally_and_finish();
  end
endmodule
bind global_interrupt_aggregator global_interrupt_aggregator_checker chk (.*);
`default_nettype wire
